// ### prr_lpf.sv
/*
  first-order low-pass stepped once per control beat.
  time constant in 0.01 s; zero passes the input straight through.
  assumes update is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
`include "prr_map.svh"
module prr_lpf (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic update,
  input wire logic [15:0] filter_time,
  input wire logic signed [31:0] din,
  output logic signed [31:0] dout
);
  logic signed [31:0] den;
  logic signed [31:0] step;

  // tau/beat is 5*T+1; the division truncates so tiny residues may remain
  always_comb begin
    den = $signed({16'h0000, filter_time}) * `PRR_BEAT_PER_HUND_S + 32'sd1;
    step = (din - dout) / den;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dout <= 32'sh00000000;
    end else if (update) begin
      dout <= dout + step;
    end
  end
endmodule : prr_lpf

// ### prr_map.svh
/*
  register offsets, reset values, field widths and timing constants of the
  process regulator.
  assumes it is included by bare name wherever the numbers are needed.
*/
`ifndef PRR_MAP_SVH
`define PRR_MAP_SVH

// ----------------------------------------------------------------------
// register offsets (word index on the register port)
// ----------------------------------------------------------------------
`define PRR_REG_REF_SEL 5'h00
`define PRR_REG_DIG_REF 5'h01
`define PRR_REG_FB_SEL 5'h02
`define PRR_REG_DIRECTION 5'h03
`define PRR_REG_DISP_SCALE 5'h04
`define PRR_REG_KP1 5'h05
`define PRR_REG_TI1 5'h06
`define PRR_REG_TD1 5'h07
`define PRR_REG_REV_CUTOFF 5'h08
`define PRR_REG_DEADBAND 5'h09
`define PRR_REG_D_CLAMP 5'h0a
`define PRR_REG_RAMP_TIME 5'h0b
`define PRR_REG_FB_FILTER 5'h0c
`define PRR_REG_OUT_FILTER 5'h0d
`define PRR_REG_KP2 5'h0e
`define PRR_REG_TI2 5'h0f
`define PRR_REG_TD2 5'h10
`define PRR_REG_SW_COND 5'h11
`define PRR_REG_SW_LOW 5'h12
`define PRR_REG_SW_HIGH 5'h13
`define PRR_REG_MAX_FREQ 5'h14
`define PRR_REG_DI_FN0 5'h15
`define PRR_NUM_CFG 25
`define PRR_REG_REF_DISP 5'h19
`define PRR_REG_FB_DISP 5'h1a
`define PRR_REG_FREQ_OUT 5'h1b

// ----------------------------------------------------------------------
// reset values and field masks
// ----------------------------------------------------------------------
`define PRR_RST_DIG_REF 16'h01f4
`define PRR_RST_DISP_SCALE 16'h03e8
`define PRR_RST_KP 16'h00c8
`define PRR_RST_TI 16'h00c8
`define PRR_RST_D_CLAMP 16'h000a
`define PRR_RST_SW_LOW 16'h00c8
`define PRR_RST_SW_HIGH 16'h0320
`define PRR_RST_MAX_FREQ 16'h1388
`define PRR_MASK_REF_SEL 16'h0007
`define PRR_MASK_FB_SEL 16'h000f
`define PRR_MASK_DIRECTION 16'h0001
`define PRR_MASK_SW_COND 16'h0003
`define PRR_MASK_DI_FN 16'h00ff

// ----------------------------------------------------------------------
// scaling, function codes and timing
// ----------------------------------------------------------------------
`define PRR_FULL_SCALE 32'sh00002710
`define PRR_TENTH_TO_HUND 32'sh0000000a
`define PRR_GAIN_UNITY 32'sh000003e8
`define PRR_BEAT_PER_HUND_S 32'sh00000005
`define PRR_BEAT_MS 32'sh00000002
`define PRR_INT_FRAC_BITS 8
`define PRR_FN_DIR_INVERT 8'h21
`define PRR_FN_GAIN_SWITCH 8'h22
`define PRR_NUM_TERMINALS 4
`define PRR_BEAT_TIME_NS 2000000
`define PRR_CLOCK_PERIOD_NS 5
`define PRR_BEAT_CYCLES (`PRR_BEAT_TIME_NS / `PRR_CLOCK_PERIOD_NS)

`endif

// ### prr_pkg.sv
/*
  enumerations for source selection and gain-set switching.
  assumes nothing of its surroundings.
*/
package prr_pkg;
  typedef enum logic [2:0] {
    REF_DIGITAL = 3'h0, REF_ANALOG_ONE = 3'h1, REF_ANALOG_TWO = 3'h2,
    REF_RESERVED = 3'h3, REF_PULSE = 3'h4, REF_COMM = 3'h5,
    REF_MULTI = 3'h6, REF_KEYPAD = 3'h7
  } prr_ref_src_e;
  typedef enum logic [3:0] {
    FB_ANALOG_ONE = 4'h0, FB_ANALOG_TWO = 4'h1, FB_RESERVED = 4'h2,
    FB_DIFF = 4'h3, FB_PULSE = 4'h4, FB_COMM = 4'h5, FB_SUM = 4'h6,
    FB_MAX = 4'h7, FB_MIN = 4'h8
  } prr_fb_src_e;
  typedef enum logic [1:0] {
    SW_NONE = 2'h0, SW_TERMINAL = 2'h1, SW_AUTO = 2'h2
  } prr_switch_e;
endpackage : prr_pkg

// ### prr_regulator.sv
/*
  process regulator: reference and feedback selection, reference ramp,
  feedback and output filtering, two gain sets, deadband, derivative clamp
  and reverse floor, producing a frequency command once per control beat.
  assumes a 200 MHz clock, register port on the same clock, analog-style
  inputs already sampled on this clock in 0.01 % units.
*/
// Overview of operation
// (R1) reference from 3-bit selected channel
// (R2) digital reference 0-100 %, default 50 %
// (R3) feedback from 4-bit selected channel combination
// (R4) direction setting flips output response sign
// (R5) function 33 terminal inverts action direction
// (R6) displays scaled so 100 % equals range
// (R7) proportional gain 100 maps full deviation
// (R8) integral reaches maximum in integral time
// (R9) derivative full when feedback moves fully
// (R10) reverse output limited by cut-off setting
// (R11) hold output inside deviation deadband
// (R12) clamp derivative term to its limit
// (R13) ramp reference at configured change time
// (R14) low-pass filter feedback, zero bypasses
// (R15) low-pass filter output, zero bypasses
// (R16) second gain set, 2-bit switch condition
// (R17) function 34 terminal selects gain set two
// (R18) auto switch interpolates between deviation thresholds
// (R19) recompute output every two millisecond beat
// (R20) sum terms, limit to maximum frequency
`timescale 1ns/1ps
`include "prr_map.svh"
module prr_regulator #(
  parameter int unsigned BEAT_CYCLES = `PRR_BEAT_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic signed [15:0] analog_input_one,
  input wire logic signed [15:0] analog_input_two,
  input wire logic signed [15:0] pulse_input,
  input wire logic signed [15:0] comm_input,
  input wire logic signed [15:0] multi_ref_input,
  input wire logic signed [15:0] keypad_pot_input,
  input wire logic [3:0] digital_input_terminal,
  output logic signed [31:0] freq_command,
  output logic [15:0] reference_display,
  output logic [15:0] feedback_display
);
  localparam int BW = $clog2(BEAT_CYCLES);
  localparam logic signed [31:0] FULL = `PRR_FULL_SCALE;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic signed [31:0] clamp(
    input logic signed [31:0] x, input logic signed [31:0] lo,
    input logic signed [31:0] hi);
    clamp = (x < lo) ? lo : ((x > hi) ? hi : x);
  endfunction : clamp

  // x * num / den with a wide product; zero divisor gives zero
  function automatic logic signed [31:0] scale_frac(
    input logic signed [31:0] x, input logic signed [31:0] num,
    input logic signed [31:0] den);
    logic signed [63:0] prod;
    prod = 64'(x) * 64'(num);
    scale_frac = (den == 32'sd0) ? 32'sd0 : 32'(prod / 64'(den));
  endfunction : scale_frac

  function automatic logic signed [31:0] uval(input logic [15:0] v);
    uval = $signed({16'h0000, v});
  endfunction : uval

  function automatic logic signed [31:0] absv(input logic signed [31:0] v);
    absv = (v < 0) ? -v : v;
  endfunction : absv

  // a + (b-a)*(x-lo)/(hi-lo), used for each gain of the two sets
  function automatic logic signed [31:0] interp(
    input logic signed [31:0] a, input logic signed [31:0] b,
    input logic signed [31:0] x, input logic signed [31:0] lo,
    input logic signed [31:0] hi);
    interp = a + scale_frac(b - a, x - lo, hi - lo);
  endfunction : interp

  function automatic logic [15:0] field_mask(input logic [4:0] idx);
    logic [15:0] m;
    m = 16'hffff;
    if (idx == `PRR_REG_REF_SEL) m = `PRR_MASK_REF_SEL;
    if (idx == `PRR_REG_FB_SEL) m = `PRR_MASK_FB_SEL;
    if (idx == `PRR_REG_DIRECTION) m = `PRR_MASK_DIRECTION;
    if (idx == `PRR_REG_SW_COND) m = `PRR_MASK_SW_COND;
    if (idx >= `PRR_REG_DI_FN0) m = `PRR_MASK_DI_FN;
    field_mask = m;
  endfunction : field_mask

  function automatic logic [15:0] reset_value(input int idx);
    logic [15:0] v;
    v = 16'h0000;
    if (idx == int'(`PRR_REG_DIG_REF)) v = `PRR_RST_DIG_REF;
    if (idx == int'(`PRR_REG_DISP_SCALE)) v = `PRR_RST_DISP_SCALE;
    if (idx == int'(`PRR_REG_KP1) || idx == int'(`PRR_REG_KP2)) v = `PRR_RST_KP;
    if (idx == int'(`PRR_REG_TI1) || idx == int'(`PRR_REG_TI2)) v = `PRR_RST_TI;
    if (idx == int'(`PRR_REG_D_CLAMP)) v = `PRR_RST_D_CLAMP;
    if (idx == int'(`PRR_REG_SW_LOW)) v = `PRR_RST_SW_LOW;
    if (idx == int'(`PRR_REG_SW_HIGH)) v = `PRR_RST_SW_HIGH;
    if (idx == int'(`PRR_REG_MAX_FREQ)) v = `PRR_RST_MAX_FREQ;
    reset_value = v;
  endfunction : reset_value

  // ----------------------------------------------------------------------
  // reset release and pin synchronisation
  // ----------------------------------------------------------------------
  logic [1:0] rst_pipe_q;
  logic rst_n;
  logic [3:0] di_sync;

  // asynchronous assert, release after two clean edges
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_q[1];

  prr_sync #(.WIDTH(4)) u_di_sync (
    .clock(clock),
    .rst_n(rst_n),
    .din(digital_input_terminal),
    .dout(di_sync)
  );

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  logic [15:0] cfg_q [0:`PRR_NUM_CFG-1];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `PRR_NUM_CFG; i++) begin
        cfg_q[i] <= reset_value(i);
      end
    end else if (reg_wr && (int'(reg_addr) < `PRR_NUM_CFG)) begin
      cfg_q[reg_addr] <= reg_wdata & field_mask(reg_addr);
    end
  end

  prr_pkg::prr_ref_src_e ref_sel;
  prr_pkg::prr_fb_src_e fb_sel;
  prr_pkg::prr_switch_e sw_cond;
  assign ref_sel = prr_pkg::prr_ref_src_e'(cfg_q[`PRR_REG_REF_SEL][2:0]);
  assign fb_sel = prr_pkg::prr_fb_src_e'(cfg_q[`PRR_REG_FB_SEL][3:0]);
  assign sw_cond = prr_pkg::prr_switch_e'(cfg_q[`PRR_REG_SW_COND][1:0]);

  // a terminal counts when its assigned function code matches and it is high
  function automatic logic fn_active(input logic [7:0] code);
    logic hit;
    hit = 1'b0;
    for (int t = 0; t < `PRR_NUM_TERMINALS; t++) begin
      if (di_sync[t] && cfg_q[int'(`PRR_REG_DI_FN0) + t][7:0] == code) begin
        hit = 1'b1;
      end
    end
    fn_active = hit;
  endfunction : fn_active

  logic invert_active, switch_active, dir_eff;
  always_comb begin // a process, so it wakes on the terminals and codes
    invert_active = fn_active(`PRR_FN_DIR_INVERT);
    switch_active = fn_active(`PRR_FN_GAIN_SWITCH);
  end
  assign dir_eff = cfg_q[`PRR_REG_DIRECTION][0] ^ invert_active; // see (R5)

  // ----------------------------------------------------------------------
  // control beat
  // ----------------------------------------------------------------------
  logic [BW-1:0] beat_cnt_q;
  logic beat;
  assign beat = (beat_cnt_q == BW'(BEAT_CYCLES - 1));

  // one update strobe every beat period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      beat_cnt_q <= '0;
    end else begin
      beat_cnt_q <= beat ? '0 : beat_cnt_q + 1'b1; // see (R19)
    end
  end

  // ----------------------------------------------------------------------
  // reference and feedback selection
  // ----------------------------------------------------------------------
  logic signed [31:0] ai1, ai2, ref_raw, ref_target, fb_raw, fb_sel_val;
  assign ai1 = 32'(analog_input_one);
  assign ai2 = 32'(analog_input_two);

  always_comb begin
    unique case (ref_sel)
      prr_pkg::REF_DIGITAL:
        ref_raw = uval(cfg_q[`PRR_REG_DIG_REF]) * `PRR_TENTH_TO_HUND; // see (R2)
      prr_pkg::REF_ANALOG_ONE: ref_raw = ai1;
      prr_pkg::REF_ANALOG_TWO: ref_raw = ai2;
      prr_pkg::REF_RESERVED: ref_raw = 32'sd0;
      prr_pkg::REF_PULSE: ref_raw = 32'(pulse_input);
      prr_pkg::REF_COMM: ref_raw = 32'(comm_input);
      prr_pkg::REF_MULTI: ref_raw = 32'(multi_ref_input);
      prr_pkg::REF_KEYPAD: ref_raw = 32'(keypad_pot_input);
    endcase
    ref_target = clamp(ref_raw, 32'sd0, FULL); // see (R1)
  end

  // codes 9..15 are not defined and select nothing
  always_comb begin
    unique case (fb_sel)
      prr_pkg::FB_ANALOG_ONE: fb_raw = ai1;
      prr_pkg::FB_ANALOG_TWO: fb_raw = ai2;
      prr_pkg::FB_DIFF: fb_raw = ai1 - ai2;
      prr_pkg::FB_PULSE: fb_raw = 32'(pulse_input);
      prr_pkg::FB_COMM: fb_raw = 32'(comm_input);
      prr_pkg::FB_SUM: fb_raw = ai1 + ai2;
      prr_pkg::FB_MAX: fb_raw = (absv(ai1) > absv(ai2)) ? absv(ai1) : absv(ai2);
      prr_pkg::FB_MIN: fb_raw = (absv(ai1) < absv(ai2)) ? absv(ai1) : absv(ai2);
      default: fb_raw = 32'sd0;
    endcase
    fb_sel_val = clamp(fb_raw, 32'sd0, FULL); // see (R3)
  end

  // ----------------------------------------------------------------------
  // reference ramp and feedback filter
  // ----------------------------------------------------------------------
  logic signed [31:0] ref_eff_q, ramp_step, fb_filt;
  logic [15:0] ramp_time;
  assign ramp_time = cfg_q[`PRR_REG_RAMP_TIME];
  // full span takes 5*T beats; step floored at one count so it always moves
  assign ramp_step = clamp(scale_frac(FULL, 32'sd1,
    uval(ramp_time) * `PRR_BEAT_PER_HUND_S), 32'sd1, FULL);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_eff_q <= 32'sd0;
    end else if (beat) begin
      if (ramp_time == 16'h0000) begin
        ref_eff_q <= ref_target; // see (R13)
      end else if (ref_eff_q < ref_target) begin
        ref_eff_q <= clamp(ref_eff_q + ramp_step, ref_eff_q, ref_target);
      end else begin
        ref_eff_q <= clamp(ref_eff_q - ramp_step, ref_target, ref_eff_q);
      end
    end
  end

  prr_lpf u_fb_filter ( // see (R14)
    .clock(clock),
    .rst_n(rst_n),
    .update(beat),
    .filter_time(cfg_q[`PRR_REG_FB_FILTER]),
    .din(fb_sel_val),
    .dout(fb_filt)
  );

  // ----------------------------------------------------------------------
  // gain set choice
  // ----------------------------------------------------------------------
  logic signed [31:0] err, dev, abs_err, sw_lo, sw_hi;
  logic signed [31:0] kp_use, ti_use, td_use;
  logic signed [31:0] kp1, ti1, td1, kp2, ti2, td2;
  assign kp1 = uval(cfg_q[`PRR_REG_KP1]);
  assign ti1 = uval(cfg_q[`PRR_REG_TI1]);
  assign td1 = uval(cfg_q[`PRR_REG_TD1]);
  assign kp2 = uval(cfg_q[`PRR_REG_KP2]);
  assign ti2 = uval(cfg_q[`PRR_REG_TI2]);
  assign td2 = uval(cfg_q[`PRR_REG_TD2]);
  assign sw_lo = uval(cfg_q[`PRR_REG_SW_LOW]) * `PRR_TENTH_TO_HUND;
  assign sw_hi = uval(cfg_q[`PRR_REG_SW_HIGH]) * `PRR_TENTH_TO_HUND;

  // positive action: error counts up when feedback sits below reference
  assign err = ref_eff_q - fb_filt;
  assign dev = dir_eff ? -err : err; // see (R4)
  assign abs_err = absv(err);

  // code 3 is undefined and behaves as no switching
  always_comb begin
    kp_use = kp1;
    ti_use = ti1;
    td_use = td1;
    if (sw_cond == prr_pkg::SW_TERMINAL && switch_active) begin // see (R17)
      kp_use = kp2;
      ti_use = ti2;
      td_use = td2;
    end else if (sw_cond == prr_pkg::SW_AUTO && abs_err >= sw_hi) begin
      kp_use = kp2; // see (R16)
      ti_use = ti2;
      td_use = td2;
    end else if (sw_cond == prr_pkg::SW_AUTO && abs_err > sw_lo) begin
      kp_use = interp(kp1, kp2, abs_err, sw_lo, sw_hi); // see (R18)
      ti_use = interp(ti1, ti2, abs_err, sw_lo, sw_hi);
      td_use = interp(td1, td2, abs_err, sw_lo, sw_hi);
    end
  end

  // ----------------------------------------------------------------------
  // regulator terms
  // ----------------------------------------------------------------------
  logic signed [31:0] integ_q, deriv_q, pid_sum_q, fb_prev_q;
  logic signed [31:0] p_term, integ_d, d_raw, d_lim, d_term, pid_sum_d;
  logic signed [31:0] int_full;
  logic in_dead;
  assign int_full = FULL <<< `PRR_INT_FRAC_BITS;
  assign in_dead = abs_err < uval(cfg_q[`PRR_REG_DEADBAND])
    * `PRR_TENTH_TO_HUND; // see (R11)
  assign d_lim = uval(cfg_q[`PRR_REG_D_CLAMP]);

  always_comb begin
    p_term = scale_frac(dev, kp_use, `PRR_GAIN_UNITY); // see (R7)
    // integral kept with fractional bits so slow rates still accumulate
    integ_d = clamp(integ_q + scale_frac(dev <<< `PRR_INT_FRAC_BITS, 32'sd1,
      clamp(ti_use, 32'sd1, FULL) * `PRR_BEAT_PER_HUND_S),
      -int_full, int_full); // see (R8)
    // derivative acts on feedback so reference steps give no kick
    d_raw = scale_frac(dir_eff ? (fb_filt - fb_prev_q) : (fb_prev_q - fb_filt),
      td_use, `PRR_BEAT_MS); // see (R9)
    d_term = clamp(d_raw, -d_lim, d_lim); // see (R12)
    pid_sum_d = clamp(p_term + (integ_d >>> `PRR_INT_FRAC_BITS) + d_term,
      -FULL, FULL); // see (R20)
  end

  // all terms advance together on the beat; inside deadband they freeze
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      integ_q <= 32'sd0;
      deriv_q <= 32'sd0;
      pid_sum_q <= 32'sd0;
      fb_prev_q <= 32'sd0;
    end else if (beat) begin
      fb_prev_q <= fb_filt;
      if (!in_dead) begin // see (R11)
        integ_q <= integ_d;
        deriv_q <= d_term;
        pid_sum_q <= pid_sum_d; // see (R19)
      end
    end
  end

  // ----------------------------------------------------------------------
  // frequency command, reverse floor and output filter
  // ----------------------------------------------------------------------
  logic signed [31:0] freq_raw, freq_cmd_q, rev_cut;
  assign rev_cut = uval(cfg_q[`PRR_REG_REV_CUTOFF]);
  assign freq_raw = scale_frac(pid_sum_q, uval(cfg_q[`PRR_REG_MAX_FREQ]), FULL);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      freq_cmd_q <= 32'sd0;
    end else begin
      freq_cmd_q <= (freq_raw < -rev_cut) ? -rev_cut : freq_raw; // see (R10)
    end
  end

  prr_lpf u_out_filter ( // see (R15)
    .clock(clock),
    .rst_n(rst_n),
    .update(beat),
    .filter_time(cfg_q[`PRR_REG_OUT_FILTER]),
    .din(freq_cmd_q),
    .dout(freq_command)
  );

  // ----------------------------------------------------------------------
  // displays and register reads
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reference_display <= 16'h0000;
      feedback_display <= 16'h0000;
    end else begin
      reference_display <= 16'(scale_frac(ref_eff_q,
        uval(cfg_q[`PRR_REG_DISP_SCALE]), FULL)); // see (R6)
      feedback_display <= 16'(scale_frac(fb_filt,
        uval(cfg_q[`PRR_REG_DISP_SCALE]), FULL));
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (int'(reg_addr) < `PRR_NUM_CFG) begin
      reg_rdata <= cfg_q[reg_addr];
    end else if (reg_addr == `PRR_REG_REF_DISP) begin
      reg_rdata <= reference_display;
    end else if (reg_addr == `PRR_REG_FB_DISP) begin
      reg_rdata <= feedback_display;
    end else if (reg_addr == `PRR_REG_FREQ_OUT) begin
      reg_rdata <= freq_command[15:0];
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_beat_free;
    !beat [*8];
  endsequence
  a_beat_spacing: assert property (beat |=> s_beat_free) // see (R19)
    else $error("update strobes too close together");
  a_dead_hold: assert property (beat && in_dead |=> // see (R11)
    $stable(pid_sum_q)) else $error("output moved inside deadband");
  a_live_update: assert property (beat && !in_dead |=> // see (R20)
    pid_sum_q == $past(pid_sum_d)) else $error("output not recomputed");
  a_reverse_floor: assert property (freq_cmd_q < 0 |-> // see (R10)
    -freq_cmd_q <= $past(rev_cut)) else $error("reverse beyond cut-off");
  a_deriv_clamp: assert property (beat && !in_dead |=> // see (R12)
    absv(deriv_q) <= $past(d_lim)) else $error("derivative out of range");
  a_out_limit: assert property (absv(pid_sum_q) <= FULL) // see (R20)
    else $error("regulator output beyond full scale");
  a_ramp_bypass: assert property (beat && !(|ramp_time) |=> // see (R13)
    ref_eff_q == $past(ref_target)) else $error("reference ramped");
  a_gain_switch: assert property (switch_active && // see (R17)
    sw_cond == prr_pkg::SW_TERMINAL |-> kp_use == kp2 && td_use == td2)
    else $error("terminal did not select second set");
  a_dir_invert: assert property (invert_active |-> dev == // see (R5)
    (cfg_q[`PRR_REG_DIRECTION][0] ? err : -err))
    else $error("direction not inverted");
  a_read_timing: assert property (reg_rd && reg_addr == // see (R2)
    `PRR_REG_DIG_REF |=> reg_rdata == $past(cfg_q[`PRR_REG_DIG_REF]))
    else $error("read data wrong or late");
endmodule : prr_regulator

// ### prr_src_model.sv
/*
  source model: analog and pulse sources feeding the regulator.
  assumes one clock shared with the regulator.
*/
`timescale 1ns/1ps
module prr_src_model (
  input wire logic clock,
  input wire logic signed [15:0] level,
  output logic signed [15:0] analog_input_one,
  output logic signed [15:0] analog_input_two,
  output logic signed [15:0] pulse_input
);
  // sources settle one clock after the level moves, like a sampled pin
  always_ff @(posedge clock) begin
    analog_input_one <= level;
    analog_input_two <= level;
    pulse_input <= level;
  end
endmodule : prr_src_model

// ### prr_sync.sv
/*
  two-flop synchroniser for level inputs from pins.
  assumes an active-low reset already synchronous to clock.
*/
`timescale 1ns/1ps
module prr_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : prr_sync

// ### tb_top.sv
/*
  bench: register port, reset values and loop output of the regulator.
  assumes the source model is compiled first; beat shortened to 20 cycles.
*/
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
  n_fail++; $display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module tb_top;
  logic clock = 0;
  logic resetn = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [4:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, ref_disp, fb_disp;
  logic [3:0] term = 0;
  logic signed [15:0] level = 0, a1, a2, pl;
  logic signed [31:0] freq;
  int n_fail = 0;
  int cmp_count = 0;
  // address beside reset read data; 1c is unmapped and reads zero
  logic [20:0] rows [11] = '{{5'h00, 16'h0000}, {5'h01, 16'h01f4},
    {5'h03, 16'h0000}, {5'h04, 16'h03e8}, {5'h05, 16'h00c8},
    {5'h06, 16'h00c8}, {5'h0a, 16'h000a}, {5'h12, 16'h00c8},
    {5'h13, 16'h0320}, {5'h14, 16'h1388}, {5'h1c, 16'h0000}};

  always #2.5 clock = ~clock;

  prr_src_model src (.clock(clock), .level(level), .analog_input_one(a1),
    .analog_input_two(a2), .pulse_input(pl));

  prr_regulator #(.BEAT_CYCLES(20)) dut (.clock(clock), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .analog_input_one(a1),
    .analog_input_two(a2), .pulse_input(pl), .comm_input(16'sh0000),
    .multi_ref_input(16'sh0000), .keypad_pot_input(16'sh0000),
    .digital_input_terminal(term), .freq_command(freq),
    .reference_display(ref_disp), .feedback_display(fb_disp));

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // reset clears the integral, so each loop case starts clean
  task automatic do_reset;
    @(posedge clock);
    resetn <= 1'b0;
    term <= 4'h0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
  endtask : do_reset

  task automatic run;
    repeat (600) @(posedge clock);
    #1;
  endtask : run

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  // main sequence: table loop, then hand-written loop cases
  initial begin
    logic [15:0] v;
    do_reset();
    foreach (rows[i]) begin
      rd(rows[i][20:16], v);
      `CHK("reset read", v, rows[i][15:0])
    end
    wr(5'h03, 16'hfffe);
    rd(5'h03, v);
    `CHK("dir mask", v, 16'h0000)
    wr(5'h05, 16'h03e8);
    wr(5'h01, 16'h03e8);
    run();
    `CHK("full out", freq, 32'sh00001388)
    `CHK("ref disp", ref_disp, 16'h03e8)
    `CHK("fb disp", fb_disp, 16'h0000)
    do_reset();
    wr(5'h03, 16'h0001);
    run();
    `CHK("reverse floor", freq, 32'sh00000000)
    do_reset();
    wr(5'h03, 16'h0001);
    wr(5'h15, 16'h0021);
    term <= 4'h1;
    level <= 16'sd2500;
    run();
    `CHK("invert", freq > 0, 1'b1)
    `CHK("fb quarter", fb_disp, 16'h00fa)
    wr(5'h02, 16'h0006);
    run();
    `CHK("fb sum", fb_disp, 16'h01f4)
    // full-width deadband: ref 50 % against fb 25 % must never move the sum
    do_reset();
    wr(5'h09, 16'h03e8);
    run();
    `CHK("deadband hold", freq, 32'sh00000000)
    stop_test();
  end

  // watchdog: the sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    stop_test();
  end
endmodule : tb_top
